// *** logic/dio_regif.sv ***
// Top of the digital I/O register interface: three ports, control word, irq gating
`timescale 1ns/100ps
module dio_regif (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [9:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rdata_oe,
  input  wire logic       base_wr,
  input  wire logic [9:0] base_wdata,
  output logic      [9:0] base_addr,
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  input  wire logic [7:0] port_b_in,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  input  wire logic [7:0] port_c_in,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe,
  output logic      [1:0] group_a_mode,
  output logic            group_b_mode,
  input  wire logic       first_port_irq_request,
  input  wire logic       second_port_irq_request,
  output logic            host_irq
);
  typedef struct packed {
    logic [9:0] base;
    logic [7:0] control;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] out_c;
    logic       first_port_irq_enable;
    logic       second_port_irq_enable;
    logic       global_irq_enable;
    logic [7:0] rdata;
    logic       rdata_oe;
    logic       irq;
  } dio_state_s;

  dio_state_s st;
  dio_state_s next_st;
  dio_bus_if  bus ();
  logic       hit;
  logic [2:0] bit_idx;
  logic       a_in;
  logic       cu_in;
  logic       b_in;
  logic       cl_in;
  logic [7:0] rd_c;

  dio_decode u_decode (
    .addr      (addr),
    .base_addr (st.base),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .wdata     (wdata),
    .hit       (hit),
    .bus       (bus.dec)
  );

  assign a_in    = st.control[dio_pkg::CW_A_DIR];
  assign cu_in   = st.control[dio_pkg::CW_CU_DIR];
  assign b_in    = st.control[dio_pkg::CW_B_DIR];
  assign cl_in   = st.control[dio_pkg::CW_CL_DIR];
  assign bit_idx = wdata[3:1];
  // port C reads per nibble owner
  assign rd_c    = {cu_in ? port_c_in[7:4] : st.out_c[7:4], cl_in ? port_c_in[3:0] : st.out_c[3:0]};

  always_comb
  begin
    next_st          = st;
    next_st.rdata_oe = 1'b0;
    // software-set base, loaded only inside legal window range, out-of-range writes ignored
    if (base_wr && base_wdata >= dio_pkg::BASE_MIN && base_wdata <= dio_pkg::BASE_MAX)
    begin
      next_st.base = {base_wdata[9:dio_pkg::WIN_BITS], 5'h00};
    end
    if (bus.wr_port_a)
    begin
      next_st.out_a = bus.wdata;
    end
    if (bus.wr_port_b)
    begin
      next_st.out_b = bus.wdata;
    end
    if (bus.wr_port_c)
    begin
      next_st.out_c = bus.wdata;
    end
    if (bus.wr_control)
    begin
      if (bus.wdata[dio_pkg::CW_FLAG])
      begin
        next_st.control = bus.wdata;
        next_st.out_a   = dio_pkg::RESET_DATA;
        next_st.out_c   = dio_pkg::RESET_DATA;
      end
      else
      begin
        next_st.out_c[bit_idx] = bus.wdata[0];
      end
    end
    // reserved bits ignored, host writes them zero
    if (bus.wr_irq_en)
    begin
      next_st.first_port_irq_enable  = bus.wdata[dio_pkg::IRQ_A_BIT];
      next_st.second_port_irq_enable = bus.wdata[dio_pkg::IRQ_B_BIT];
    end
    if (bus.wr_global)
    begin
      next_st.global_irq_enable = bus.wdata[dio_pkg::GLOBAL_EN_BIT];
    end
    // read mux, control and irq regs read nothing
    if (bus.rd_sel_a)
    begin
      next_st.rdata    = a_in ? port_a_in : st.out_a;
      next_st.rdata_oe = 1'b1;
    end
    else if (bus.rd_sel_b)
    begin
      next_st.rdata    = b_in ? port_b_in : st.out_b;
      next_st.rdata_oe = 1'b1;
    end
    else if (bus.rd_sel_c)
    begin
      next_st.rdata    = rd_c;
      next_st.rdata_oe = 1'b1;
    end
    next_st.irq = st.global_irq_enable &
                  ((first_port_irq_request & st.first_port_irq_enable) |
                   (second_port_irq_request & st.second_port_irq_enable));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st                        <= '0;
      st.base                   <= dio_pkg::RESET_BASE;
      st.control                <= dio_pkg::RESET_CONTROL;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Port B latch keeps its value over mode writes; it only holds whatever was last written
  assign port_a_out   = st.out_a;
  assign port_b_out   = st.out_b;
  assign port_c_out   = st.out_c;
  assign port_a_oe    = {8{~a_in}};
  assign port_b_oe    = {8{~b_in}};
  assign port_c_oe    = {{4{~cu_in}}, {4{~cl_in}}};
  assign group_a_mode = st.control[dio_pkg::CW_A_MODE_HI:dio_pkg::CW_A_MODE_LO];
  assign group_b_mode = st.control[dio_pkg::CW_B_MODE];
  assign base_addr    = st.base;
  assign rdata        = st.rdata;
  assign rdata_oe     = st.rdata_oe;
  assign host_irq     = st.irq;

  a_mode_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && bus.wdata[7]) |=> (st.out_a == 8'h00 && st.out_c == 8'h00))
    else $error("mode write did not clear port latches");
  a_bit_set_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && !bus.wdata[7]) |=> (st.out_c[$past(bit_idx)] == $past(bus.wdata[0])))
    else $error("port C bit set/reset wrong");
  a_bit_others: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && !bus.wdata[7])
    |=> (((st.out_c ^ $past(st.out_c)) & ~(8'h01 << $past(bit_idx))) == 8'h00))
    else $error("set/reset disturbed other port C bits");
  a_ctrl_keep: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && !bus.wdata[7]) |=> $stable(st.control))
    else $error("bit set/reset changed control");
  a_mode_load: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && bus.wdata[7]) |=> (st.control == $past(bus.wdata)))
    else $error("mode word not loaded");
  a_mode_fields: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && bus.wdata[7])
    |=> (group_a_mode == $past(bus.wdata[6:5]) && group_b_mode == $past(bus.wdata[2])))
    else $error("group mode fields wrong");
  a_dir_oe: assert property (@(posedge ref_clk) disable iff (rst)
    (bus.wr_control && bus.wdata[7])
    |=> (port_a_oe[0] == !$past(bus.wdata[4]) && port_c_oe[7] == !$past(bus.wdata[3])
         && port_b_oe[0] == !$past(bus.wdata[1]) && port_c_oe[0] == !$past(bus.wdata[0])))
    else $error("direction not applied");
  a_irq_a_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (first_port_irq_request && st.first_port_irq_enable && st.global_irq_enable) |=> host_irq)
    else $error("port A request not passed");
  a_irq_a_block: assert property (@(posedge ref_clk) disable iff (rst)
    (first_port_irq_request && !st.first_port_irq_enable
     && !(second_port_irq_request && st.second_port_irq_enable)) |=> !host_irq)
    else $error("port A request passed while disabled");
  a_irq_b_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (second_port_irq_request && st.second_port_irq_enable && st.global_irq_enable) |=> host_irq)
    else $error("port B request not passed");
  a_irq_b_block: assert property (@(posedge ref_clk) disable iff (rst)
    (second_port_irq_request && !st.second_port_irq_enable
     && !(first_port_irq_request && st.first_port_irq_enable)) |=> !host_irq)
    else $error("port B request passed while disabled");
  a_global_block: assert property (@(posedge ref_clk) disable iff (rst)
    !st.global_irq_enable |=> !host_irq)
    else $error("irq without global enable");
  a_global_load: assert property (@(posedge ref_clk) disable iff (rst)
    bus.wr_global |=> (st.global_irq_enable == $past(bus.wdata[dio_pkg::GLOBAL_EN_BIT])))
    else $error("global enable not loaded");
  a_irq_en_load: assert property (@(posedge ref_clk) disable iff (rst)
    bus.wr_irq_en |=> (st.first_port_irq_enable == $past(bus.wdata[dio_pkg::IRQ_A_BIT])
                       && st.second_port_irq_enable == $past(bus.wdata[dio_pkg::IRQ_B_BIT])))
    else $error("port irq enables not loaded");
  a_irq_or: assert property (@(posedge ref_clk) disable iff (rst)
    host_irq |-> $past(st.global_irq_enable && ((first_port_irq_request && st.first_port_irq_enable)
                 || (second_port_irq_request && st.second_port_irq_enable))))
    else $error("irq without gated request");
  a_base_range: assert property (@(posedge ref_clk) disable iff (rst)
    st.base >= 10'h100 && st.base <= 10'h3E0 && st.base[4:0] == 5'h00)
    else $error("base outside legal window");
  a_outside_win: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && !hit) |=> ($stable(st.out_a) && $stable(st.out_b) && $stable(st.out_c)
                         && $stable(st.control)))
    else $error("write outside window took effect");
  a_base_load: assert property (@(posedge ref_clk) disable iff (rst)
    (base_wr && base_wdata >= 10'h100 && base_wdata <= 10'h3E0)
    |=> (base_addr == {$past(base_wdata[9:5]), 5'h00}))
    else $error("legal base not loaded");
  a_base_keep: assert property (@(posedge ref_clk) disable iff (rst)
    (base_wr && (base_wdata < 10'h100 || base_wdata > 10'h3E0))
    |=> $stable(base_addr))
    else $error("illegal base taken");
  a_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    bus.wr_port_a |=> (st.out_a == $past(bus.wdata)))
    else $error("port A write lost");
  a_write_b: assert property (@(posedge ref_clk) disable iff (rst)
    bus.wr_port_b |=> (st.out_b == $past(bus.wdata)))
    else $error("port B write lost");
  a_write_c: assert property (@(posedge ref_clk) disable iff (rst)
    bus.wr_port_c |=> (st.out_c == $past(bus.wdata)))
    else $error("port C write lost");
  a_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    bus.rd_sel_a |=> (rdata_oe && rdata == ($past(a_in) ? $past(port_a_in) : $past(st.out_a))))
    else $error("port A read wrong");
  a_read_b: assert property (@(posedge ref_clk) disable iff (rst)
    bus.rd_sel_b |=> (rdata_oe && rdata == ($past(b_in) ? $past(port_b_in) : $past(st.out_b))))
    else $error("port B read wrong");
  a_read_c: assert property (@(posedge ref_clk) disable iff (rst)
    bus.rd_sel_c |=> (rdata_oe
                      && rdata[7:4] == ($past(cu_in) ? $past(port_c_in[7:4]) : $past(st.out_c[7:4]))
                      && rdata[3:0] == ($past(cl_in) ? $past(port_c_in[3:0]) : $past(st.out_c[3:0]))))
    else $error("port C read wrong");
  a_no_read_wo: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && hit && (addr[4:0] == dio_pkg::OFF_CONTROL || addr[4:0] == dio_pkg::OFF_PORT_IRQ_EN
                      || addr[4:0] == dio_pkg::OFF_GLOBAL_EN))
    |=> !rdata_oe)
    else $error("write-only register answered a read");
endmodule

// *** logic/dio_pkg.sv ***
// Shared constants for the digital I/O register interface
package dio_pkg;
  localparam logic [9:0] BASE_MIN        = 10'h100;
  localparam logic [9:0] BASE_MAX        = 10'h3E0;
  localparam int         WIN_BITS        = 5;
  localparam logic [4:0] OFF_PORT_A      = 5'h00;
  localparam logic [4:0] OFF_PORT_B      = 5'h01;
  localparam logic [4:0] OFF_PORT_C      = 5'h02;
  localparam logic [4:0] OFF_CONTROL     = 5'h03;
  localparam logic [4:0] OFF_PORT_IRQ_EN = 5'h14;
  localparam logic [4:0] OFF_GLOBAL_EN   = 5'h15;
  localparam int         CW_FLAG         = 7;
  localparam int         CW_A_MODE_HI    = 6;
  localparam int         CW_A_MODE_LO    = 5;
  localparam int         CW_A_DIR        = 4;
  localparam int         CW_CU_DIR       = 3;
  localparam int         CW_B_MODE       = 2;
  localparam int         CW_B_DIR        = 1;
  localparam int         CW_CL_DIR       = 0;
  localparam int         IRQ_A_BIT       = 0;
  localparam int         IRQ_B_BIT       = 1;
  localparam int         GLOBAL_EN_BIT   = 2;
  localparam logic [7:0] RESET_CONTROL   = 8'h9B;
  localparam logic [7:0] RESET_DATA      = 8'h00;
  localparam logic [1:0] RESET_B_MODE    = 2'h0;
  localparam logic [9:0] RESET_BASE      = 10'h100;
endpackage

// *** logic/dio_bus_if.sv ***
// Decoded register strobes between the address decoder and the port core
`timescale 1ns/100ps
interface dio_bus_if;
  logic       wr_port_a;
  logic       wr_port_b;
  logic       wr_port_c;
  logic       wr_control;
  logic       wr_irq_en;
  logic       wr_global;
  logic       rd_sel_a;
  logic       rd_sel_b;
  logic       rd_sel_c;
  logic [7:0] wdata;
  modport dec (output wr_port_a, wr_port_b, wr_port_c, wr_control, wr_irq_en, wr_global,
               rd_sel_a, rd_sel_b, rd_sel_c, wdata);
  modport core (input wr_port_a, wr_port_b, wr_port_c, wr_control, wr_irq_en, wr_global,
                rd_sel_a, rd_sel_b, rd_sel_c, wdata);
endinterface

// *** logic/dio_decode.sv ***
// Window decoder: maps a bus access inside the 32-byte window to register strobes
`timescale 1ns/100ps
module dio_decode (
  input  wire logic [9:0] addr,
  input  wire logic [9:0] base_addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  output logic            hit,
  dio_bus_if.dec          bus
);
  logic [4:0] off;
  logic       in_win;

  assign in_win = (addr[9:dio_pkg::WIN_BITS] == base_addr[9:dio_pkg::WIN_BITS]);
  assign off    = addr[dio_pkg::WIN_BITS-1:0];
  assign hit    = in_win;
  assign bus.wdata = wdata;

  always_comb
  begin
    bus.wr_port_a  = 1'b0;
    bus.wr_port_b  = 1'b0;
    bus.wr_port_c  = 1'b0;
    bus.wr_control = 1'b0;
    bus.wr_irq_en  = 1'b0;
    bus.wr_global  = 1'b0;
    bus.rd_sel_a   = 1'b0;
    bus.rd_sel_b   = 1'b0;
    bus.rd_sel_c   = 1'b0;
    if (in_win && off == dio_pkg::OFF_PORT_A)
    begin
      bus.wr_port_a = wr_en;
      bus.rd_sel_a  = rd_en;
    end
    else if (in_win && off == dio_pkg::OFF_PORT_B)
    begin
      bus.wr_port_b = wr_en;
      bus.rd_sel_b  = rd_en;
    end
    else if (in_win && off == dio_pkg::OFF_PORT_C)
    begin
      bus.wr_port_c = wr_en;
      bus.rd_sel_c  = rd_en;
    end
    else if (in_win && off == dio_pkg::OFF_CONTROL)
    begin
      bus.wr_control = wr_en;
    end
    else if (in_win && off == dio_pkg::OFF_PORT_IRQ_EN)
    begin
      bus.wr_irq_en = wr_en;
    end
    else if (in_win && off == dio_pkg::OFF_GLOBAL_EN)
    begin
      bus.wr_global = wr_en;
    end
  end
endmodule

// *** verification/dio_pin_model.sv ***
// Pin-side model: lines read back the latch where driven, the outside level elsewhere
`timescale 1ns/100ps
module dio_pin_model (
  input  wire logic [7:0] out_v,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin
);
  // Outside level differs from any latch value used, so a wrong enable shows up
  assign pin = (oe & out_v) | (~oe & ext);
endmodule

// *** verification/dio_regif_tb.sv ***
// Self-checking bench for the digital I/O register interface
`timescale 1ns/100ps
module dio_regif_tb;
  logic       ref_clk, rst, wr_en, rd_en, base_wr, req_a, req_b, rdata_oe, group_b_mode, host_irq;
  logic [9:0] addr, base_wdata, base_addr, base_cur;
  logic [7:0] wdata, rdata, ext_a, ext_b, ext_c, pin_a, pin_b, pin_c;
  logic [7:0] port_a_out, port_b_out, port_c_out, port_a_oe, port_b_oe, port_c_oe;
  logic [1:0] group_a_mode;
  int         n_mismatch, checks, i;
  // 200 ns host recovery, ten 20 ns cycles
  localparam int RECOVERY_CYCLES = 10;

  dio_regif i_dio_regif (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe), .base_wr(base_wr), .base_wdata(base_wdata),
    .base_addr(base_addr), .port_a_in(pin_a), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .port_b_in(pin_b), .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_c_in(pin_c),
    .port_c_out(port_c_out), .port_c_oe(port_c_oe), .group_a_mode(group_a_mode),
    .group_b_mode(group_b_mode), .first_port_irq_request(req_a), .second_port_irq_request(req_b),
    .host_irq(host_irq));
  dio_pin_model i_dio_pin_model_a (.out_v(port_a_out), .oe(port_a_oe), .ext(ext_a), .pin(pin_a));
  dio_pin_model i_dio_pin_model_b (.out_v(port_b_out), .oe(port_b_oe), .ext(ext_b), .pin(pin_b));
  dio_pin_model i_dio_pin_model_c (.out_v(port_c_out), .oe(port_c_oe), .ext(ext_c), .pin(pin_c));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_raw(input logic [9:0] a, input logic [7:0] d);
    repeat (RECOVERY_CYCLES) @(posedge ref_clk);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [4:0] off, input logic [7:0] d);
    wr_raw(base_cur + 10'(off), d);
  endtask

  // No answer expected where none is set
  task automatic rd(input logic [4:0] off, input logic [7:0] exp, input logic none);
    repeat (RECOVERY_CYCLES) @(posedge ref_clk);
    @(posedge ref_clk);
    addr  <= base_cur + 10'(off);
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata_oe, !none);
    if (!none)
      chk(rdata, exp);
  endtask

  task automatic set_base(input logic [9:0] v);
    @(posedge ref_clk);
    base_wdata <= v;
    base_wr    <= 1'b1;
    @(posedge ref_clk);
    base_wr    <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst        = 1'b1;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    base_wr    = 1'b0;
    req_a      = 1'b0;
    req_b      = 1'b0;
    addr       = 10'h000;
    wdata      = 8'h00;
    base_wdata = 10'h000;
    base_cur   = 10'h100;
    ext_a      = 8'hA5;
    ext_b      = 8'h3C;
    ext_c      = 8'hC3;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(base_addr, 24'h100);
    chk({port_a_oe, port_b_oe, port_c_oe}, 24'h0);
    rd(5'h00, ext_a, 1'b0);
    rd(5'h01, ext_b, 1'b0);
    rd(5'h02, ext_c, 1'b0);
    rd(5'h03, 8'h00, 1'b1);
    rd(5'h14, 8'h00, 1'b1);
    rd(5'h15, 8'h00, 1'b1);
    rd(5'h04, 8'h00, 1'b1);
    wr(5'h03, 8'h80);
    chk({port_a_oe, port_b_oe, port_c_oe}, 24'hFFFFFF);
    wr(5'h00, 8'h12);
    wr(5'h01, 8'h34);
    wr(5'h02, 8'h56);
    chk({port_a_out, port_b_out, port_c_out}, 24'h123456);
    rd(5'h02, 8'h56, 1'b0);
    wr(5'h03, 8'h90);
    chk({port_a_out, port_c_out}, 24'h0);
    rd(5'h00, ext_a, 1'b0);
    wr(5'h03, 8'h80);
    for (i = 0; i < 8; i++)
    begin
      wr(5'h03, {4'h7, 3'(i), 1'b1});
      chk(port_c_out, 8'(8'hFF >> (7 - i)));
    end
    for (i = 0; i < 8; i++)
    begin
      wr(5'h03, {4'h0, 3'(i), 1'b0});
      chk(port_c_out, 8'(8'hFF << (i + 1)));
    end
    for (i = 0; i < 16; i++)
    begin
      wr(5'h03, {3'h4, i[3], i[2], 1'b0, i[1], i[0]});
      chk({port_a_oe, port_b_oe, port_c_oe}, {{8{~i[3]}}, {8{~i[1]}}, {4{~i[2]}}, {4{~i[0]}}});
    end
    wr(5'h03, 8'hE4);
    chk({group_a_mode, group_b_mode}, 24'h7);
    wr(5'h03, 8'hC0);
    chk({group_a_mode, group_b_mode}, 24'h4);
    wr(5'h03, 8'hA0);
    chk({group_a_mode, group_b_mode}, 24'h2);
    set_base(10'h3F0);
    set_base(10'h0E0);
    chk(base_addr, 24'h100);
    set_base(10'h3E0);
    chk(base_addr, 24'h3E0);
    set_base(10'h180);
    base_cur = 10'h180;
    wr(5'h03, 8'h80);
    wr_raw(10'h100, 8'h77);
    chk(port_a_out, 24'h0);
    wr(5'h00, 8'h77);
    chk(port_a_out, 24'h77);
    for (i = 0; i < 32; i++)
    begin
      wr(5'h14, {6'h00, i[1:0]});
      wr(5'h15, {5'h00, i[2], 2'h0});
      @(posedge ref_clk);
      req_a <= i[3];
      req_b <= i[4];
      repeat (2) @(posedge ref_clk);
      #1;
      chk(host_irq, i[2] & ((i[0] & i[3]) | (i[1] & i[4])));
    end
    // Mid-run reset must bring back base, enables and directions
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    base_cur = 10'h100;
    @(posedge ref_clk);
    #1;
    chk({base_addr, host_irq, port_a_oe}, {10'h100, 1'b0, 8'h00});
    rd(5'h00, ext_a, 1'b0);
    test_done;
  end

  // Run needs about 1550 cycles; a hang is cut well beyond that
  initial
  begin
    #1000000;
    n_mismatch++;
    test_done;
  end
endmodule
